// >>> src/srsr_map.svh
// Constants of the read-status responder: command codes, status bit
// positions, register offsets and reset values.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SRSR_MAP_SVH
`define SRSR_MAP_SVH

`define SRSR_CMD_LEGACY_A 8'hC0
`define SRSR_CMD_LEGACY_B 8'hD0
`define SRSR_CMD_STATUS 8'hDE
`define SRSR_OPCODE 8'hDD
`define SRSR_BYTE_COUNT 8'h03
`define SRSR_LAST_TX 2'h3

`define SRSR_S1_ABORT 6
`define SRSR_S1_LINK 5
`define SRSR_S1_FORCE 4
`define SRSR_S1_RELOAD 3
`define SRSR_S2_ALIVE 3
`define SRSR_S2_IRQ 2
`define SRSR_S2_ICR 1

`define SRSR_PS_DR 2'h0
`define SRSR_PS_D0U 2'h1
`define SRSR_PS_D0 2'h2
`define SRSR_PS_D3 2'h3

`define SRSR_OFF_CTRL 8'h00
`define SRSR_OFF_STAT 8'h04
`define SRSR_OFF_EVT 8'h08
`define SRSR_OFF_EVT_CLR 8'h0C
`define SRSR_OFF_EVT_EN 8'h10

`define SRSR_CTRL_CHG_EN 8
`define SRSR_CTRL_FORCE 9
`define SRSR_CTRL_SINGLE 10
// Arbitrary default responder address
`define SRSR_ADDR_RST 7'h49

`define SRSR_EV_REQ 0
`define SRSR_EV_CHG 1
`define SRSR_EV_SERVED 2

`endif

// >>> src/srsr_pkg.sv
// Types of the read-status responder.
// Assumes srsr_map.svh is on the include path.
package srsr_pkg;
	`include "srsr_map.svh"

	typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_SKIP} srsr_st_t;

	typedef struct packed {
		srsr_st_t st;
		logic [3:0] bitcnt;
		logic is_cmd;
		logic cmd_ok;
		logic ack;
		logic go_tx;
		logic [7:0] sh;
		logic [1:0] tx_idx;
	} srsr_bus_t;

	typedef struct packed {
		logic [6:0] addr;
		logic chg_en;
		logic force_link;
		logic single;
	} srsr_ctrl_t;

	typedef struct packed {
		logic scl_p;
		logic sda_p;
		logic req_p;
		srsr_bus_t bus;
		logic sda_oe;
		logic alert_oe;
		logic abort_f;
		logic reload_f;
		logic icr_f;
		logic [1:0] alive;
		logic [7:0] s1_prev;
		logic [7:0] snap1;
		logic [7:0] snap2;
		srsr_ctrl_t ctrl;
		logic [2:0] evt;
		logic [2:0] evt_en;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
		logic hready;
		logic irq;
	} srsr_state_t;
endpackage : srsr_pkg

// >>> src/srsr_sync.sv
// Two-stage synchroniser for signals that arrive from outside clk_i.
// Assumes each bit is a quasi-static level or slow edge.
`timescale 1ns/100ps
module srsr_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	if (W < 1) begin : g_bad_w
		$error("srsr_sync: W must be at least 1");
	end

	logic [W-1:0] meta_q;

	// Reset to 1: the bus lines idle high
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q <= '1;
			q_o <= '1;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule : srsr_sync

// >>> src/srsr_top.sv
// SMBus read-status responder with alert and AHB-Lite register slave.
// Assumes SMBus pins come from outside and are oversampled by clk_i;
// function status inputs come from logic on clk_i.
//
// Operation
// - Alert controller when it requests a status read
// - Alert on status byte one change if enabled
// - Accept read status under three command codes
// - Dedicated command always answers with partial-status opcode
// - Answer count three, opcode, byte one, byte two
// - Answer legacy commands at once, without clock stretching
// - Byte one bit 6: abort since last read
// - Bit 5 link up, bit 4 force-hold mirror
// - Bit 3: defaults reloaded since last read
// - Bits 1:0 power state, highest across functions when single is set, else function 0
// - Byte two bit 3: driver alive indication
// - Bit 2: any interrupt line asserted
// - Bit 1: cause register read since last read
// - Driver alive if either function alive
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "srsr_map.svh"
module srsr_top
	import srsr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic irq_o,
	// SMBus pins
	input wire logic smb_clk_i,
	input wire logic smb_dat_i,
	output logic smb_dat_o,
	output logic smb_dat_oe_o,
	input wire logic smb_alert_i,
	output logic smb_alert_o,
	output logic smb_alert_oe_o,
	input wire logic mc_status_req_i,
	// Device status, same clock
	input wire logic abort_evt_i,
	input wire logic reload_evt_i,
	input wire logic link_up_i,
	input wire logic [1:0] drv_alive_set_i,
	input wire logic pci_rst_i,
	input wire logic [1:0] irq_line_i,
	input wire logic [1:0] icr_read_i,
	input wire logic [3:0] power_state_i
);
	//////////////////////////////////////////////////////////////////////
	// Helpers

	// Higher value means a higher-ranked power state
	function automatic logic [1:0] ps_rank(input logic [1:0] ps);
		unique case (ps)
			`SRSR_PS_D0: ps_rank = 2'h3;
			`SRSR_PS_D0U: ps_rank = 2'h2;
			`SRSR_PS_DR: ps_rank = 2'h1;
			`SRSR_PS_D3: ps_rank = 2'h0;
		endcase
	endfunction : ps_rank

	function automatic logic cmd_valid(input logic [7:0] c);
		cmd_valid = (c == `SRSR_CMD_LEGACY_A) || (c == `SRSR_CMD_LEGACY_B) ||
			(c == `SRSR_CMD_STATUS);
	endfunction : cmd_valid

	//////////////////////////////////////////////////////////////////////
	// Synchronisers; alert input is only observed, not used

	logic [2:0] syn;
	srsr_sync #(.W(3)) u_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.d_i({smb_clk_i, smb_dat_i, mc_status_req_i}),
		.q_o(syn)
	);
	logic scl, sda, req;
	assign scl = syn[2];
	assign sda = syn[1];
	assign req = syn[0];

	srsr_state_t s_q, s_d;

	//////////////////////////////////////////////////////////////////////
	// Live status bytes

	logic [1:0] ps0, ps1, ps_out;
	logic [7:0] s1_live, s2_live;
	always_comb begin
		ps0 = power_state_i[1:0];
		ps1 = power_state_i[3:2];
		ps_out = ps0;
		if (s_q.ctrl.single && (ps_rank(ps1) > ps_rank(ps0))) begin
			ps_out = ps1;
		end
		s1_live = 8'h00;
		s1_live[`SRSR_S1_ABORT] = s_q.abort_f;
		s1_live[`SRSR_S1_LINK] = link_up_i;
		s1_live[`SRSR_S1_FORCE] = s_q.ctrl.force_link;
		s1_live[`SRSR_S1_RELOAD] = s_q.reload_f;
		s1_live[1:0] = ps_out;
		s2_live = 8'h00;
		s2_live[`SRSR_S2_ALIVE] = |s_q.alive;
		s2_live[`SRSR_S2_IRQ] = |irq_line_i;
		s2_live[`SRSR_S2_ICR] = s_q.icr_f;
	end

	//////////////////////////////////////////////////////////////////////
	// Next state

	logic scl_rise, scl_fall, start, stop, served, req_rise, chg;
	logic [7:0] rx_byte;
	logic [2:0] ev_set;
	logic ad_sel, ad_rd;

	always_comb begin
		s_d = s_q;
		s_d.scl_p = scl;
		s_d.sda_p = sda;
		s_d.req_p = req;
		scl_rise = scl & ~s_q.scl_p;
		scl_fall = ~scl & s_q.scl_p;
		start = scl & s_q.scl_p & s_q.sda_p & ~sda;
		stop = scl & s_q.scl_p & ~s_q.sda_p & sda;
		req_rise = req & ~s_q.req_p;
		rx_byte = s_q.bus.sh;
		served = 1'b0;

		// SMBus slave; no clock stretching, so every answer is immediate
		if (start) begin
			s_d.bus.st = ST_RX;
			s_d.bus.bitcnt = 4'h0;
			s_d.bus.is_cmd = 1'b0;
			s_d.bus.ack = 1'b0;
			s_d.sda_oe = 1'b0;
		end else if (stop) begin
			s_d.bus.st = ST_IDLE;
			s_d.bus.cmd_ok = 1'b0;
			s_d.sda_oe = 1'b0;
		end else begin
			unique case (s_q.bus.st)
				ST_IDLE, ST_SKIP: begin
					s_d.sda_oe = 1'b0;
				end
				ST_RX: begin
					if (scl_rise && !s_q.bus.ack) begin
						s_d.bus.sh = {s_q.bus.sh[6:0], sda};
						s_d.bus.bitcnt = s_q.bus.bitcnt + 4'h1;
					end else if (scl_fall && s_q.bus.ack) begin
						s_d.bus.ack = 1'b0;
						s_d.sda_oe = 1'b0;
						if (s_q.bus.go_tx) begin
							// Read-status cycle begins: freeze bytes, clear stickies
							s_d.bus.st = ST_TX;
							s_d.bus.tx_idx = 2'h0;
							s_d.bus.sh = `SRSR_BYTE_COUNT;
							s_d.sda_oe = ~s_d.bus.sh[7];
							s_d.snap1 = s1_live;
							s_d.snap2 = s2_live;
							served = 1'b1;
						end
					end else if (scl_fall && s_q.bus.bitcnt == 4'h8) begin
						s_d.bus.bitcnt = 4'h0;
						s_d.bus.go_tx = 1'b0;
						s_d.bus.st = ST_SKIP;
						if (s_q.bus.is_cmd) begin
							if (cmd_valid(rx_byte)) begin
								s_d.bus.cmd_ok = 1'b1;
								s_d.bus.ack = 1'b1;
								s_d.bus.st = ST_RX;
							end
						end else if (rx_byte[7:1] == s_q.ctrl.addr) begin
							if (!rx_byte[0]) begin
								s_d.bus.is_cmd = 1'b1;
								s_d.bus.ack = 1'b1;
								s_d.bus.st = ST_RX;
							end else if (s_q.bus.cmd_ok) begin
								s_d.bus.go_tx = 1'b1;
								s_d.bus.ack = 1'b1;
								s_d.bus.st = ST_RX;
							end
						end
						s_d.sda_oe = s_d.bus.ack;
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						if (s_q.bus.bitcnt == 4'h8) begin
							s_d.bus.bitcnt = 4'h0;
							if (sda || s_q.bus.tx_idx == `SRSR_LAST_TX) begin
								s_d.bus.st = ST_SKIP;
							end else begin
								s_d.bus.tx_idx = s_q.bus.tx_idx + 2'h1;
								unique case (s_q.bus.tx_idx)
									2'h0: s_d.bus.sh = `SRSR_OPCODE;
									2'h1: s_d.bus.sh = s_q.snap1;
									default: s_d.bus.sh = s_q.snap2;
								endcase
							end
						end else begin
							s_d.bus.bitcnt = s_q.bus.bitcnt + 4'h1;
						end
					end else if (scl_fall) begin
						// Release for the master acknowledge, else drive low for a zero
						if (s_q.bus.bitcnt == 4'h8) begin
							s_d.sda_oe = 1'b0;
						end else begin
							s_d.sda_oe = ~s_q.bus.sh[3'(4'h7 - s_q.bus.bitcnt)];
						end
					end
				end
			endcase
		end

		// Sticky flags: a new event wins over the clear of a read cycle
		s_d.abort_f = abort_evt_i | (s_q.abort_f & ~served);
		s_d.reload_f = reload_evt_i | (s_q.reload_f & ~served);
		s_d.icr_f = (|icr_read_i) | (s_q.icr_f & ~served);
		for (int f = 0; f < 2; f++) begin
			if (drv_alive_set_i[f]) begin
				s_d.alive[f] = 1'b1;
			end else if (pci_rst_i || power_state_i[2*f +: 2] == `SRSR_PS_D3) begin
				s_d.alive[f] = 1'b0;
			end
		end

		// Notification
		s_d.s1_prev = s1_live;
		chg = s_q.ctrl.chg_en && (s1_live != s_q.s1_prev);
		if (req_rise || chg) begin
			s_d.alert_oe = 1'b1;
		end else if (served) begin
			s_d.alert_oe = 1'b0;
		end

		// Event status: set wins over a software clear
		ev_set = 3'h0;
		ev_set[`SRSR_EV_REQ] = req_rise;
		ev_set[`SRSR_EV_CHG] = chg;
		ev_set[`SRSR_EV_SERVED] = served;

		// AHB-Lite: write in data phase, read data registered at address phase
		s_d.hready = 1'b1;
		ad_sel = hsel_i && htrans_i[1] && hready_i;
		ad_rd = ad_sel && !hwrite_i;
		s_d.a_wr = ad_sel && hwrite_i;
		s_d.a_addr = haddr_i[7:0];
		s_d.evt = s_q.evt;
		if (s_q.a_wr) begin
			unique case (s_q.a_addr)
				`SRSR_OFF_CTRL: begin
					s_d.ctrl.addr = hwdata_i[6:0];
					s_d.ctrl.chg_en = hwdata_i[`SRSR_CTRL_CHG_EN];
					s_d.ctrl.force_link = hwdata_i[`SRSR_CTRL_FORCE];
					s_d.ctrl.single = hwdata_i[`SRSR_CTRL_SINGLE];
				end
				`SRSR_OFF_EVT_CLR: s_d.evt = s_q.evt & ~hwdata_i[2:0];
				`SRSR_OFF_EVT_EN: s_d.evt_en = hwdata_i[2:0];
				default: ;
			endcase
		end
		s_d.evt = s_d.evt | ev_set;
		s_d.hrdata = 32'h0000_0000;
		if (ad_rd) begin
			unique case (haddr_i[7:0])
				`SRSR_OFF_CTRL: s_d.hrdata = {21'h00_0000, s_q.ctrl.single,
					s_q.ctrl.force_link, s_q.ctrl.chg_en, 1'b0, s_q.ctrl.addr};
				`SRSR_OFF_STAT: s_d.hrdata = {8'h00, s2_live, s1_live, 7'h00,
					s_q.alert_oe};
				`SRSR_OFF_EVT: s_d.hrdata = {29'h0000_0000, s_q.evt};
				`SRSR_OFF_EVT_EN: s_d.hrdata = {29'h0000_0000, s_q.evt_en};
				default: s_d.hrdata = 32'h0000_0000;
			endcase
		end
		s_d.irq = |(s_d.evt & s_d.evt_en);
	end

	//////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '0;
			s_q.scl_p <= 1'b1;
			s_q.sda_p <= 1'b1;
			// Synchroniser resets high; match it so reset makes no request edge
			s_q.req_p <= 1'b1;
			s_q.bus.st <= ST_IDLE;
			s_q.ctrl.addr <= `SRSR_ADDR_RST;
		end else begin
			s_q <= s_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Outputs, all from flops; open-drain pins only ever pull low

	assign hrdata_o = s_q.hrdata;
	assign hreadyout_o = s_q.hready;
	assign hresp_o = 1'b0 & s_q.hready;
	assign irq_o = s_q.irq;
	assign smb_dat_o = 1'b0 & s_q.sda_oe;
	assign smb_dat_oe_o = s_q.sda_oe;
	assign smb_alert_o = 1'b0 & s_q.alert_oe;
	assign smb_alert_oe_o = s_q.alert_oe;

	logic unused;
	assign unused = ^{haddr_i[31:8], hsize_i, smb_alert_i};
endmodule : srsr_top

// >>> bench/srsr_props.sv
// Assertions on the pins of the read-status responder.
// Assumes a bind into srsr_top and an SMBus clock far slower than clk_i.
`timescale 1ns/100ps
module srsr_props (
	// Watched pins
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic smb_clk_i,
	input wire logic smb_dat_o,
	input wire logic smb_dat_oe_o,
	input wire logic smb_alert_o,
	input wire logic smb_alert_oe_o,
	input wire logic mc_status_req_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_okay; hresp_o == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_rdy; $past(arst_n_i) |-> hreadyout_o; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state");
	property p_nodat; smb_dat_o == 1'b0; endproperty
	a_nodat: assert property (p_nodat) else $error("data pin driven high");
	property p_noalrt; smb_alert_o == 1'b0; endproperty
	a_noalrt: assert property (p_noalrt) else $error("alert pin driven high");
	property p_rdz; !$past(hsel_i && htrans_i[1] && hready_i && !hwrite_i) |-> hrdata_o == 32'h0;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data without read");
	property p_alert; $rose(mc_status_req_i) |-> ##[1:8] smb_alert_oe_o; endproperty
	a_alert: assert property (p_alert) else $error("no alert on request");
	property p_datchg; $changed(smb_dat_oe_o) |-> !smb_clk_i; endproperty
	a_datchg: assert property (p_datchg) else $error("data moved in clock high");
	property p_datrise; $rose(smb_dat_oe_o) |-> !smb_clk_i ##1 !smb_clk_i; endproperty
	a_datrise: assert property (p_datrise) else $error("data driven late");
	c_alert: cover property ($rose(smb_alert_oe_o));
	c_drive: cover property ($rose(smb_dat_oe_o));
	c_read: cover property (hsel_i && htrans_i[1] && !hwrite_i);
endmodule : srsr_props
bind srsr_top srsr_props u_props (
	.clk_i(clk_i),
	.arst_n_i(arst_n_i),
	.hsel_i(hsel_i),
	.htrans_i(htrans_i),
	.hwrite_i(hwrite_i),
	.hready_i(hready_i),
	.hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o),
	.smb_clk_i(smb_clk_i),
	.smb_dat_o(smb_dat_o),
	.smb_dat_oe_o(smb_dat_oe_o),
	.smb_alert_o(smb_alert_o),
	.smb_alert_oe_o(smb_alert_oe_o),
	.mc_status_req_i(mc_status_req_i)
);

// >>> bench/srsr_mc_model.sv
// Controller model: bit-banged SMBus master, 160 ns bit time.
// Assumes pull-ups, so released lines read high; clock idles high.
`timescale 1ns/100ps
module srsr_mc_model (
	// Wire levels
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	localparam time Q = 40;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		#Q sda_o = b;
		#Q scl_o = 1'b1;
		#Q r = sda_i;
		#Q scl_o = 1'b0;
	endtask : bit_io
	// Byte MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(m, a);
	endtask : xfer
	task automatic start;
		#Q sda_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_o = 1'b0;
		#Q scl_o = 1'b0;
	endtask : start
	// Nack of the last byte ends the block read
	task automatic rd_status(input logic [6:0] ad, input logic [7:0] cmd, output logic [31:0] rx,
			output logic [31:0] ak);
		logic [7:0] r;
		logic a;
		ak = '0;
		// Keep pin changes off the rising edges of the system clock
		#3;
		start();
		xfer({ad, 1'b0}, 1'b1, r, ak[2]);
		xfer(cmd, 1'b1, r, ak[1]);
		start();
		xfer({ad, 1'b1}, 1'b1, r, ak[0]);
		for (int k = 3; k >= 0; k--) begin
			xfer(8'hFF, k == 0, r, a);
			rx[k*8+:8] = r;
		end
		#Q sda_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_o = 1'b1;
	endtask : rd_status
endmodule : srsr_mc_model

// >>> bench/srsr_tb.sv
// Self-checking bench: AHB-Lite tasks, controller model on the SMBus pins.
// Assumes srsr_pkg, srsr_top, checker and model are compiled first.
`timescale 1ns/100ps
module testbench;
	logic clk_i, arst_n_i, hsel_i, hwrite_i, mc_status_req_i, abort_evt_i, reload_evt_i;
	logic link_up_i, pci_rst_i, hreadyout_o, hresp_o, irq_o, scl, mc_sda;
	logic smb_dat_o, smb_dat_oe_o, smb_alert_o, smb_alert_oe_o;
	logic [1:0] htrans_i, drv_alive_set_i, irq_line_i, icr_read_i;
	logic [3:0] power_state_i;
	logic [7:0] s1, s2;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, r, rx, ak, lf, e, g;
	logic [31:0] exp_q[$], got_q[$];
	logic [7:0] cmds[3] = '{8'hC0, 8'hD0, 8'hDE};
	logic [3:0] pw[3] = '{4'h4, 4'hB, 4'hF};
	logic [15:0] st[3] = '{16'h3108, 16'h3208, 16'h3300};
	int n_errors, n_tests;
	wire logic sda = mc_sda & ~smb_dat_oe_o;
	srsr_top uut (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(3'h2),
		.hwdata_i(hwdata_i),
		.hready_i(hreadyout_o),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.irq_o(irq_o),
		.smb_clk_i(scl),
		.smb_dat_i(sda),
		.smb_dat_o(smb_dat_o),
		.smb_dat_oe_o(smb_dat_oe_o),
		.smb_alert_i(~smb_alert_oe_o),
		.smb_alert_o(smb_alert_o),
		.smb_alert_oe_o(smb_alert_oe_o),
		.mc_status_req_i(mc_status_req_i),
		.abort_evt_i(abort_evt_i),
		.reload_evt_i(reload_evt_i),
		.link_up_i(link_up_i),
		.drv_alive_set_i(drv_alive_set_i),
		.pci_rst_i(pci_rst_i),
		.irq_line_i(irq_line_i),
		.icr_read_i(icr_read_i),
		.power_state_i(power_state_i)
	);
	srsr_mc_model mc (.scl_o(scl), .sda_o(mc_sda), .sda_i(sda));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic note(input logic [31:0] ev, input logic [31:0] gv);
		exp_q.push_back(ev);
		got_q.push_back(gv);
	endtask : note
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic edge_rdy;
		int n;
		n = 0;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) begin
			if (++n > 20) begin
				n_errors++;
				print_verdict();
			end
			@(posedge clk_i);
		end
	endtask : edge_rdy
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		edge_rdy();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		edge_rdy();
		r = hrdata_o;
	endtask : ahb
	task automatic wait_alert;
		int n;
		for (n = 0; n < 50 && smb_alert_oe_o !== 1'b1; n++) @(posedge clk_i);
		note(32'h1, {31'h0, smb_alert_oe_o});
	endtask : wait_alert
	// Live status bytes, given time to settle
	task automatic stat(input logic [15:0] ev);
		repeat (3) @(posedge clk_i);
		ahb(1'b0, 8'h04, 32'h0);
		note({16'h0, ev}, {16'h0, r[15:8], r[23:16]});
	endtask : stat
	initial forever begin
		@(negedge clk_i);
		while (got_q.size() > 0) begin
			e = exp_q.pop_front();
			g = got_q.pop_front();
			n_tests++;
			if (g !== e) begin
				n_errors++;
				$display("mismatch at %0t: got %h expected %h", $time, g, e);
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{arst_n_i, hsel_i, hwrite_i, mc_status_req_i, abort_evt_i, reload_evt_i} = '0;
		{link_up_i, pci_rst_i, htrans_i, drv_alive_set_i, irq_line_i, icr_read_i} = '0;
		{power_state_i, haddr_i, hwdata_i} = '0;
		n_errors = 0;
		n_tests = 0;
		lf = 32'h3CC4;
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		ahb(1'b0, 8'h00, 32'h0);
		note(32'h49, r);
		ahb(1'b1, 8'h10, 32'h7);
		ahb(1'b0, 8'h10, 32'h0);
		note(32'h7, r);
		ahb(1'b0, 8'h20, 32'h0);
		note(32'h0, r);
		$display("test registers done");
		mc_status_req_i <= 1'b1;
		wait_alert();
		ahb(1'b0, 8'h08, 32'h0);
		note(32'h1, r);
		note(32'h1, {31'h0, irq_o});
		ahb(1'b1, 8'h10, 32'h0);
		repeat (2) @(posedge clk_i);
		note(32'h0, {31'h0, irq_o});
		mc_status_req_i <= 1'b0;
		ahb(1'b1, 8'h0C, 32'h7);
		ahb(1'b1, 8'h10, 32'h7);
		ahb(1'b0, 8'h08, 32'h0);
		note(32'h0, r);
		$display("test alert and interrupt done");
		ahb(1'b1, 8'h00, 32'h249);
		for (int k = 0; k < 3; k++) begin
			lf = lfsr(lf);
			link_up_i <= lf[0];
			irq_line_i <= lf[2:1];
			power_state_i <= 4'h2;
			{abort_evt_i, reload_evt_i, icr_read_i, drv_alive_set_i} <= 6'b11_10_01;
			@(posedge clk_i);
			{abort_evt_i, reload_evt_i, icr_read_i, drv_alive_set_i} <= 6'h0;
			s1 = {2'b01, lf[0], 5'b11010};
			s2 = {5'h01, |lf[2:1], 2'b10};
			repeat (20) @(posedge clk_i);
			mc.rd_status(7'h49, cmds[k], rx, ak);
			note({8'h03, 8'hDD, s1, s2}, rx);
			note(32'h0, ak);
			mc.rd_status(7'h49, cmds[k], rx, ak);
			note({8'h03, 8'hDD, s1 & 8'hB7, s2 & 8'hFD}, rx);
		end
		$display("test status reads done");
		mc.rd_status(7'h49, 8'hD4, rx, ak);
		note(32'hFFFF_FFFF, rx);
		note(32'h3, ak);
		mc.rd_status(7'h22, 8'hDE, rx, ak);
		note(32'h7, ak);
		$display("test refusals done");
		link_up_i <= 1'b1;
		irq_line_i <= 2'h0;
		pci_rst_i <= 1'b1;
		@(posedge clk_i);
		pci_rst_i <= 1'b0;
		stat(16'h3200);
		drv_alive_set_i <= 2'h2;
		@(posedge clk_i);
		drv_alive_set_i <= 2'h0;
		stat(16'h3208);
		ahb(1'b1, 8'h00, 32'h649);
		for (int k = 0; k < 3; k++) begin
			power_state_i <= pw[k];
			stat(st[k]);
		end
		$display("test power and alive done");
		ahb(1'b1, 8'h00, 32'h349);
		repeat (10) @(posedge clk_i);
		note(32'h0, {31'h0, smb_alert_oe_o});
		link_up_i <= 1'b0;
		wait_alert();
		ahb(1'b0, 8'h08, 32'h0);
		note(32'h2, r & 32'h2);
		$display("test change alert done");
		repeat (5) @(posedge clk_i);
		print_verdict();
	end
endmodule : testbench
